// >>> sp3_far_model.sv
// Far side: reference clock source, link sender and link receiver.
// Assumes the device's link pins are wired straight across.
`timescale 1ns/1ps
`default_nettype none
module sp3_far_model (
   // Mode
   input  wire logic       ser,
   input  wire logic [3:0] rep,
   // Toward the device
   output logic            ref_clk,
   output logic            tx_en,
   output logic [1:0]      tx_d,
   output logic            tx_err,
   // From the device
   input  wire logic       rx_v,
   input  wire logic [1:0] rx_d,
   input  wire logic       tx_clk,
   input  wire logic       rx_clk
);
   logic [7:0] tx_q[$], rx_q[$], sh;
   logic       hunt, prev;
   int         cnt, nb;
   // Launch mid-period so the synchroniser never races the edge
   wire        lclk = ser ? tx_clk : ~ref_clk;
   wire        sclk = ser ? rx_clk : ref_clk;
   initial begin
      {tx_en, tx_d, tx_err, ref_clk} = 5'h00;
      forever #80 ref_clk = ~ref_clk;
   end
   task automatic unit(input logic [1:0] v);
      @(posedge lclk);
      tx_en <= 1'b1;
      tx_d <= ser ? {~v[0], v[0]} : v;
   endtask
   task automatic send(input logic err);
      tx_err <= err;
      for (int i = 0; i < 6; i++) unit(i == 5 ? 2'h3 : ser ? {1'b0, i > 3 || !i[0]} : 2'h1);
      foreach (tx_q[k])
         for (int b = 0; b < 8; b += ser ? 1 : 2)
            unit(ser ? {1'b0, tx_q[k][b]} : tx_q[k][b +: 2]);
      @(posedge lclk);
      tx_en <= 1'b0;
      tx_d <= ~tx_d;
      tx_err <= 1'b0;
   endtask
   // Preamble ends at the first pair of ones; bytes come LSB first
   always @(posedge sclk) begin
      if (rx_v !== 1'b1) begin
         {cnt, nb} = 0;
         {hunt, prev} = 2'b10;
      end else begin
         if (cnt % rep == rep / 2) begin
            if (hunt) hunt = !(ser ? rx_d[0] && prev : rx_d == 2'h3);
            else begin
               sh = ser ? {rx_d[0], sh[7:1]} : {rx_d, sh[7:2]};
               nb += ser ? 1 : 2;
               if (nb == 8) begin
                  rx_q.push_back(sh);
                  nb = 0;
               end
            end
            prev = rx_d[0];
         end
         cnt++;
      end
   end
endmodule
`default_nettype wire

// >>> sp3_port_map.vh
// Constants for the third switch port's reduced and serial data link.
// Assumes the system clock and link rates named below.
`ifndef SP3_PORT_MAP_VH
`define SP3_PORT_MAP_VH

// System clock and serial link bit rate, in MHz
`define SP3_SYS_CLK_MHZ     50
`define SP3_SER_BIT_MHZ     10
// Serial bit clock divider and the count at which its clock falls
`define SP3_SER_DIV         (`SP3_SYS_CLK_MHZ / `SP3_SER_BIT_MHZ)
`define SP3_SER_FALL        3
// Reference edges per di-bit at the slow line rate
`define SP3_SLOW_REPEAT     10

// Frame framing
`define SP3_PREAMBLE_BYTE   8'h55
`define SP3_SFD_BYTE        8'hD5
`define SP3_PREAMBLE_LAST   3'h6
`define SP3_PREAMBLE_DONE   3'h7
`define SP3_BYTE_BITS       4'h8

// Widths
`define SP3_DIBIT_W         2
`define SP3_SYNC_W          5

`endif

// >>> sp3_port_sva.sv
// Checker bound to the port-3 link block.
// Assumes mode pins change only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module sp3_port_sva (
   // Clock, reset, mode
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       port_serial_mode_in,
   input wire logic       port_full_duplex_in,
   // Link and fabric outputs
   input wire logic       port_rx_valid_out,
   input wire logic [1:0] port_rx_data_out,
   input wire logic       port_collision_out,
   input wire logic       port_tx_clock,
   input wire logic       port_rx_clock,
   input wire logic       ing_end,
   input wire logic       ing_bad,
   input wire logic       ing_collision
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_clk_pair: assert property (port_tx_clock == port_rx_clock)
      else $error("bit clocks differ");
   a_clk_shape: assert property ($rose(port_tx_clock) |=>
      port_tx_clock [*2] ##1 !port_tx_clock [*2] ##1 port_tx_clock) else $error("bad bit clock");
   a_clk_idle: assert property (!port_serial_mode_in |-> !port_tx_clock)
      else $error("bit clock in reduced mode");
   a_bit1_low: assert property (port_serial_mode_in |-> !port_rx_data_out[1])
      else $error("serial bit 1 set");
   a_no_ser_col: assert property (!port_serial_mode_in |-> !port_collision_out)
      else $error("serial collision in reduced mode");
   a_col_cause: assert property (ing_collision |-> !port_full_duplex_in &&
      !port_serial_mode_in && $past(port_rx_valid_out)) else $error("bad reduced collision");
   a_ser_col_cause: assert property (port_collision_out |->
      !port_full_duplex_in && $past(port_rx_valid_out)) else $error("bad serial collision");
   a_data_hold: assert property ($changed(port_rx_data_out) |=>
      $stable(port_rx_data_out) [*3]) else $error("data not held a step");
   c_bad_end: cover property (ing_end && ing_bad);
   c_col: cover property (ing_collision);
   c_ser_col: cover property (port_collision_out);
endmodule
bind sp3_link_port sp3_port_sva chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
   .port_serial_mode_in(port_serial_mode_in), .port_full_duplex_in(port_full_duplex_in),
   .port_rx_valid_out(port_rx_valid_out), .port_rx_data_out(port_rx_data_out),
   .port_collision_out(port_collision_out), .port_tx_clock(port_tx_clock),
   .port_rx_clock(port_rx_clock), .ing_end(ing_end), .ing_bad(ing_bad),
   .ing_collision(ing_collision));
`default_nettype wire

// >>> sp3_rmii_sni_port.v
// Data link of switch port 3 in reduced (di-bit) and serial (7-wire) modes.
// Assumes the fabric side runs on sys_clk; all link pins are asynchronous
// and pass sp3_sync before use. Mode, speed and duplex are static levels.
`timescale 1ns/1ps
`default_nettype none
`include "sp3_port_map.vh"

// How it works
// R1: Reduced link carries frames at 10 or 100 Mb/s on the same pins.
// R2: Reduced mode is timed by an external 50 MHz reference clock input.
// R3: Independent two-bit transmit and receive data paths in reduced mode.
// R4: All reduced-mode activity steps on reference clock rising edges only; ing_collision here updates on every sys_clk cycle.
// R5: Device drives valid and two receive bits; takes enable and two transmit bits.
// R6: No receive-error output exists on the reduced link.
// R7: Error input marks the incoming frame as bad so the fabric drops it.
// R8: Reduced-mode collision: own valid and far enable active together, half duplex.
// R9: Board ties unused transmit bits 3:2 and error input low.
// R10: Same port works against an external PHY or another MAC.
// R11: MAC-to-MAC: outputs cross to inputs, shared clock, error unused.
// R12: Serial mode: device is the PHY on a seven-signal link.
// R13: Serial mode moves one bit per bit clock on data bit 0.
// R14: Serial mode: enable marks incoming bits, valid output marks outgoing bits.
// R15: Serial half duplex: collision output while controller transmits into busy link.
// R16: Serial mode: device sources both transmit and receive bit clocks.
// R17: Reduced mode launches and samples on reference clock rising edges.
module sp3_link_port (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       rst_b,
   // Static configuration
   input  wire       port_serial_mode_in,
   input  wire       port_speed_100_in,
   input  wire       port_full_duplex_in,
   // Link pins, same set toward a PHY or a MAC [R10] [R11]
   input  wire       port_reference_clock_in,
   input  wire       port_tx_enable_in,
   input  wire [1:0] port_tx_data_in,
   input  wire       port_tx_error_in,
   output reg        port_rx_valid_out,
   output reg  [1:0] port_rx_data_out,
   output reg        port_collision_out,
   output reg        port_tx_clock,
   output reg        port_rx_clock,
   // Fabric egress stream (sent on the link)
   input  wire       eg_valid,
   input  wire [7:0] eg_data,
   input  wire       eg_last,
   output wire       eg_ready,
   // Fabric ingress stream (received from the link)
   output reg        ing_valid,
   output reg  [7:0] ing_data,
   output reg        ing_first,
   output reg        ing_end,
   output reg        ing_bad,
   output reg        ing_collision
);

   localparam [1:0] EG_IDLE = 2'd0;
   localparam [1:0] EG_PRE  = 2'd1;
   localparam [1:0] EG_DATA = 2'd2;
   localparam [1:0] IN_IDLE = 2'd0;
   localparam [1:0] IN_HUNT = 2'd1;
   localparam [1:0] IN_DATA = 2'd2;
   localparam integer DIV_N  = `SP3_SER_DIV;
   localparam integer FALL_N = `SP3_SER_FALL;
   localparam integer REP_N  = `SP3_SLOW_REPEAT;
   localparam [2:0] SER_LAST = DIV_N[2:0] - 3'h1;
   localparam [2:0] SER_FALL = FALL_N[2:0];
   localparam [3:0] REP_LAST = REP_N[3:0] - 4'h1;

   // Bits moved per link step
   function [3:0] step_bits;
      input serial;
      begin
         step_bits = serial ? 4'h1 : 4'h2;
      end
   endfunction

   // Link pin synchronisation
   wire [`SP3_SYNC_W-1:0] pins_s;
   wire                   ref_s;
   wire                   en_s;
   wire                   err_s;
   wire [1:0]             txd_s;

   sp3_sync #(
      .W (`SP3_SYNC_W)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in ({port_reference_clock_in, port_tx_enable_in, port_tx_error_in,
                  port_tx_data_in}),
      .sync_q   (pins_s)
   );

   assign ref_s = pins_s[4];
   assign en_s  = pins_s[3];
   assign err_s = pins_s[2];
   assign txd_s = pins_s[1:0];

   // Link step generation
   reg        ref_prev_q;
   reg [3:0]  rep_q;
   reg [2:0]  div_q;
   wire       ref_rise;
   wire       rmii_tick;
   wire       ser_tick;
   wire       tick;
   wire [3:0] nbits;

   assign ref_rise  = ref_s & ~ref_prev_q;                             // [R2] [R17]
   assign rmii_tick = ref_rise & (port_speed_100_in | (rep_q == 4'h0)); // [R1] [R4]
   assign ser_tick  = (div_q == SER_FALL);                             // [R13]
   assign tick      = port_serial_mode_in ? ser_tick : rmii_tick;      // [R12]
   assign nbits     = step_bits(port_serial_mode_in);                  // [R3] [R13]

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev_q    <= 1'b0;
         rep_q         <= 4'h0;
         div_q         <= 3'h0;
         port_tx_clock <= 1'b0;
         port_rx_clock <= 1'b0;
      end else begin
         ref_prev_q <= ref_s;
         // Slow rate holds each di-bit for ten reference edges
         if (ref_rise) begin
            rep_q <= (rep_q == REP_LAST) ? 4'h0 : rep_q + 4'h1;            // [R1]
         end
         div_q <= (div_q == SER_LAST) ? 3'h0 : div_q + 3'h1;
         // Bit clocks fall where data changes, so partner samples mid-bit
         port_tx_clock <= port_serial_mode_in & (div_q < SER_FALL);        // [R16]
         port_rx_clock <= port_serial_mode_in & (div_q < SER_FALL);        // [R16]
      end
   end

   // Egress: preamble, delimiter, then fabric bytes, LSB first
   reg [1:0] eg_state_q;
   reg [7:0] eg_sh_q;
   reg [3:0] eg_left_q;
   reg [2:0] pre_cnt_q;
   reg       eg_last_q;
   wire      byte_done;
   wire      fetch_now;

   assign byte_done = tick & (eg_left_q == nbits);
   assign fetch_now = byte_done & (((eg_state_q == EG_PRE) & (pre_cnt_q == `SP3_PREAMBLE_DONE))
                                   | ((eg_state_q == EG_DATA) & ~eg_last_q));
   assign eg_ready  = fetch_now;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         eg_state_q        <= EG_IDLE;
         eg_sh_q           <= 8'h00;
         eg_left_q         <= 4'h0;
         pre_cnt_q         <= 3'h0;
         eg_last_q         <= 1'b0;
         port_rx_valid_out <= 1'b0;
         port_rx_data_out  <= 2'h0;
      end else if (tick) begin
         case (eg_state_q)
            EG_IDLE: begin
               port_rx_valid_out <= 1'b0;
               port_rx_data_out  <= 2'h0;
               eg_last_q         <= 1'b0;
               if (eg_valid) begin
                  eg_state_q <= EG_PRE;
                  eg_sh_q    <= `SP3_PREAMBLE_BYTE;
                  eg_left_q  <= `SP3_BYTE_BITS;
                  pre_cnt_q  <= 3'h0;
               end
            end
            EG_PRE, EG_DATA: begin
               port_rx_valid_out <= 1'b1;                                 // [R5] [R14]
               port_rx_data_out  <= port_serial_mode_in ? {1'b0, eg_sh_q[0]}
                                                        : eg_sh_q[1:0];   // [R3] [R13]
               eg_sh_q   <= port_serial_mode_in ? {1'b0, eg_sh_q[7:1]}
                                                : {2'b00, eg_sh_q[7:2]};
               eg_left_q <= eg_left_q - nbits;
               if (byte_done) begin
                  eg_left_q <= `SP3_BYTE_BITS;
                  if (fetch_now) begin
                     // Underrun ends the frame early; no buffer to cover it
                     if (eg_valid) begin
                        eg_state_q <= EG_DATA;
                        eg_sh_q    <= eg_data;
                        eg_last_q  <= eg_last;
                     end else begin
                        eg_state_q <= EG_IDLE;
                     end
                  end else if (eg_state_q == EG_PRE) begin
                     pre_cnt_q <= pre_cnt_q + 3'h1;
                     eg_sh_q   <= (pre_cnt_q == `SP3_PREAMBLE_LAST) ? `SP3_SFD_BYTE
                                                                     : `SP3_PREAMBLE_BYTE;
                  end else begin
                     eg_state_q <= EG_IDLE;
                  end
               end
            end
            default: begin
               eg_state_q <= EG_IDLE;
            end
         endcase
      end
   end

   // Ingress: hunt for the delimiter's closing ones, then assemble bytes
   reg [1:0] in_state_q;
   reg [7:0] in_sh_q;
   reg [3:0] in_cnt_q;
   reg       in_prev_q;
   reg       in_err_q;
   reg       in_first_q;
   wire      sfd_seen;
   wire      half_col;
   wire [7:0] in_next;

   assign sfd_seen = port_serial_mode_in ? (txd_s[0] & in_prev_q) : (txd_s == 2'b11);
   assign in_next  = port_serial_mode_in ? {txd_s[0], in_sh_q[7:1]}
                                         : {txd_s, in_sh_q[7:2]};
   // Both directions busy at once only counts in half duplex
   assign half_col = ~port_full_duplex_in & port_rx_valid_out & en_s;     // [R8] [R15]

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_state_q         <= IN_IDLE;
         in_sh_q            <= 8'h00;
         in_cnt_q           <= 4'h0;
         in_prev_q          <= 1'b0;
         in_err_q           <= 1'b0;
         in_first_q         <= 1'b0;
         ing_valid          <= 1'b0;
         ing_data           <= 8'h00;
         ing_first          <= 1'b0;
         ing_end            <= 1'b0;
         ing_bad            <= 1'b0;
         ing_collision      <= 1'b0;
         port_collision_out <= 1'b0;
      end else begin
         ing_valid          <= 1'b0;
         ing_end            <= 1'b0;
         ing_collision      <= ~port_serial_mode_in & half_col;            // [R8]
         port_collision_out <= port_serial_mode_in & half_col;             // [R15]
         if (tick) begin
            if (!en_s) begin
               if (in_state_q == IN_DATA) begin
                  ing_end <= 1'b1;
                  // Error flag or a torn last byte makes the frame bad
                  ing_bad <= in_err_q | err_s | (in_cnt_q != 4'h0);        // [R6] [R7]
               end
               in_state_q <= IN_IDLE;
               in_prev_q  <= 1'b0;
            end else begin
               in_prev_q <= txd_s[0];
               case (in_state_q)
                  IN_IDLE: begin
                     in_state_q <= IN_HUNT;                                // [R14]
                     in_err_q   <= err_s;                                  // [R7]
                  end
                  IN_HUNT: begin
                     in_err_q <= in_err_q | err_s;
                     if (sfd_seen) begin
                        in_state_q <= IN_DATA;
                        in_cnt_q   <= 4'h0;
                        in_first_q <= 1'b1;
                     end
                  end
                  IN_DATA: begin
                     in_err_q <= in_err_q | err_s;                         // [R7]
                     in_sh_q  <= in_next;
                     if (in_cnt_q + nbits == `SP3_BYTE_BITS) begin
                        in_cnt_q   <= 4'h0;
                        ing_valid  <= 1'b1;
                        ing_data   <= in_next;
                        ing_first  <= in_first_q;
                        in_first_q <= 1'b0;
                     end else begin
                        in_cnt_q <= in_cnt_q + nbits;
                     end
                  end
                  default: begin
                     in_state_q <= IN_IDLE;
                  end
               endcase
            end
         end
      end
   end

endmodule

`default_nettype wire

// >>> sp3_sync.v
// Two-flop synchroniser for pin-level inputs.
// Assumes inputs are levels from outside the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module sp3_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         sys_clk,
   input  wire         rst_b,
   // Async levels in, synchronous levels out
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_q
);

   reg [W-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

endmodule

`default_nettype wire

// >>> test_switch_port3_rmii_sni_if.sv
// Self-checking bench for the port-3 link block.
// Assumes the far-side model and the checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module test_switch_port3_rmii_sni_if;
   logic       sys_clk, rst_b, ser, s100, fd, eg_valid, eg_last, eg_ready, ref_clk, tx_en;
   logic       tx_err, rx_v, col, txc, rxc, ing_valid, ing_first, ing_end, ing_bad, ing_col;
   logic       bad_q, col_seen;
   logic [1:0] tx_d, rx_d;
   logic [3:0] rep;
   logic [7:0] eg_data, ing_data;
   logic [8:0] got_q[$];
   int         fail_count, compares, ends;
   sp3_link_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .port_serial_mode_in(ser),
      .port_speed_100_in(s100), .port_full_duplex_in(fd), .port_reference_clock_in(ref_clk),
      .port_tx_enable_in(tx_en), .port_tx_data_in(tx_d), .port_tx_error_in(tx_err),
      .port_rx_valid_out(rx_v), .port_rx_data_out(rx_d), .port_collision_out(col),
      .port_tx_clock(txc), .port_rx_clock(rxc), .eg_valid(eg_valid), .eg_data(eg_data),
      .eg_last(eg_last), .eg_ready(eg_ready), .ing_valid(ing_valid), .ing_data(ing_data),
      .ing_first(ing_first), .ing_end(ing_end), .ing_bad(ing_bad), .ing_collision(ing_col));
   sp3_far_model far_u (.ser(ser), .rep(rep), .ref_clk(ref_clk), .tx_en(tx_en), .tx_d(tx_d),
      .tx_err(tx_err), .rx_v(rx_v), .rx_d(rx_d), .tx_clk(txc), .rx_clk(rxc));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (ing_valid === 1'b1) got_q.push_back({ing_first, ing_data});
      if (ing_end === 1'b1) begin
         ends++;
         bad_q = ing_bad;
      end
      if (ing_col === 1'b1 || col === 1'b1) col_seen = 1'b1;
   end
   task check(input logic [8:0] exp, input logic [8:0] got);
      compares++;
      if (got !== exp) begin
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
         fail_count++;
      end
   endtask
   function logic [7:0] pat(input int k);
      return 8'hFF - 8'h31 * k[7:0];
   endfunction
   task set_mode(input logic m, input logic h, input logic f);
      rst_b = 1'b0;
      {ser, s100, fd} = {m, h, f};
      rep = h ? 4'h1 : 4'hA;
      repeat (3) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
   endtask
   task t_egress(input int n);
      int k, i;
      k = 0;
      far_u.rx_q.delete();
      {eg_valid, eg_last, eg_data} = {1'b1, n == 1, pat(0)};
      for (i = 0; k < n && i < 20000; i++) begin
         @(negedge sys_clk);
         if (eg_ready === 1'b1) begin
            k++;
            @(posedge sys_clk);
            #1 {eg_valid, eg_last, eg_data} = {k < n, k == n - 1, pat(k)};
         end
      end
      for (i = 0; i < 6000 && far_u.rx_q.size() < n; i++) @(posedge sys_clk);
      repeat (400) @(posedge sys_clk);
      #1 check(9'(n), 9'(far_u.rx_q.size()));
      for (i = 0; i < n; i++) check({1'b0, pat(i)}, {1'b0, far_u.rx_q[i]});
      $display("egress test done");
   endtask
   task t_ingress(input logic err);
      got_q.delete();
      ends = 0;
      far_u.tx_q = '{pat(1), pat(2), pat(3)};
      far_u.send(err);
      repeat (30) @(posedge sys_clk);
      #1 check(9'h003, 9'(got_q.size()));
      for (int i = 0; i < 3; i++) check({i == 0, pat(i + 1)}, got_q[i]);
      check({7'h00, 1'b1, err}, {ends[7:0], bad_q});
      $display("ingress test done");
   endtask
   task t_coll(input logic exp);
      col_seen = 1'b0;
      fork
         t_egress(4);
         begin
            repeat (150) @(posedge sys_clk);
            #1 far_u.tx_q = '{8'h12};
            far_u.send(1'b0);
         end
      join
      check({8'h00, exp}, {8'h00, col_seen});
      $display("collision test done");
   endtask
   task test_done;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {rst_b, ser, s100, fd, rep, eg_valid, eg_last, eg_data} = {4'h3, 4'h1, 10'h000};
      {fail_count, compares, ends} = 0;
      repeat (20) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 t_egress(3);
      t_ingress(1'b0);
      t_ingress(1'b1);
      t_coll(1'b0);
      set_mode(1'b0, 1'b0, 1'b1);
      t_egress(2);
      set_mode(1'b1, 1'b1, 1'b1);
      t_egress(2);
      t_ingress(1'b0);
      set_mode(1'b0, 1'b1, 1'b0);
      t_coll(1'b1);
      set_mode(1'b1, 1'b1, 1'b0);
      t_coll(1'b1);
      test_done;
   end
   // Whole run needs about 9000 cycles; allow over five times that
   initial begin
      #1000000;
      fail_count++;
      test_done;
   end
endmodule
`default_nettype wire
